// *** design/quad_io_read_otp_defines.vh ***
// Purpose: Shared constants of the quad I/O read and extra-page access block.
// Assumes: Registers sit on word-aligned byte offsets of a 32-bit Wishbone slave.
// Notes: Definitions only.
`ifndef QUAD_IO_READ_OTP_DEFINES_VH
`define QUAD_IO_READ_OTP_DEFINES_VH

// Register byte offsets.
`define OFF_STATUS2 8'h00
`define OFF_PROT1 8'h04
`define OFF_CMD 8'h08
`define OFF_BUF_PTR 8'h0c
`define OFF_BUF_DATA 8'h10

// Status register two fields.
`define S2_OTP_E 0
`define S2_OTP_L 1
`define S2_PROT_LOCK 2
`define S2_ECC_E 3
`define S2_BUF 4
`define S2_RESET 5'h18

// Protection register one fields.
`define P1_WP_E 5
`define P1_SRP_LO 6
`define P1_SRP_HI 7
`define P1_RESET 8'h00

// Command register fields and operations.
`define CMD_OP_BIT 16
`define OP_PAGE_READ 1'b0
`define OP_PROG_EXEC 1'b1

// Link command and page layout.
`define QIO_READ_4B 8'hec
`define PG_UID 16'h0000
`define PG_PARAM 16'h0001
`define PG_OTP_FIRST 16'h0002
`define PG_OTP_LAST 16'h000b
`define UID_BYTES 12'd512
`define PARAM_BYTES 12'd768
`define DATA_BYTES 12'd2048

// Timing counts in link clocks.
`define ADDR_CLKS 4'd8
`define DUMMY_BUF_CLKS 4'd6
`define DUMMY_CONT_CLKS 4'd10

`endif

// *** design/quad_io_read_otp.v ***
// Purpose: Quad I/O four-byte-address read and extra-page access of a serial NAND.
// Assumes: Link pins are asynchronous and sampled by i_clk; mode 0 link clock.
// Notes: Page moves, programming and locking are started from the register bus.
//
// How it works
// [RULE1] Address and data move four bits per clock.
// [RULE2] Buffer mode streams from column to buffer end.
// [RULE3] After last buffer byte, pins go high impedance.
// [RULE4] Continuous mode wraps into following pages; the code wraps to column 0 of the same buffer instead.
// [RULE5] Write-protect enable blocks the quad read.
// [RULE6] Page 00h ID, 01h parameter, 02h-0Bh OTP.
// [RULE7] ID and parameter read-only; OTP program-only.
// [RULE8] ID record times sixteen, parameter record thrice.
// [RULE9] OTP enable bit selects extra-page addressing.
// [RULE10] Page read loads buffer; busy shows loading.
// [RULE11] OTP mode forces buffer read format.
// [RULE12] ECC enable applies to extra-page reads; the code uses it only for check bytes on program execute.
// [RULE13] OTP erased; program clears bits until locked.
// [RULE14] Program execute copies buffer into OTP page.
// [RULE15] ECC check bytes written into spare area.
// [RULE16] Lock bit plus program execute locks OTP.
// [RULE17] Protection register holds protect, select, enable.
// [RULE18] Register lock needs both protect bits set.
// [RULE19] Undefined parameter bytes read as zero.
// [RULE20] Parameter record repeats at 256 and 512.
// [RULE21] Dummy clocks keep the pins released.
`timescale 1ns/1ps
`include "quad_io_read_otp_defines.vh"
module quad_io_read_otp #(
  parameter [7:0] MFR_ID = 8'h5a,
  parameter [255:0] UID_RECORD = 256'h0123456789abcdeffedcba9876543210_0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_sclk,
  input wire i_cs_n,
  input wire [3:0] i_io,
  output reg [3:0] o_io,
  output reg [3:0] o_io_oe,
  output reg o_busy
);
  localparam [11:0] BUF_LAST = 12'd2111;
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_CMD = 3'd1;
  localparam [2:0] ST_ADDR = 3'd2;
  localparam [2:0] ST_DUMMY = 3'd3;
  localparam [2:0] ST_DATA = 3'd4;
  localparam [2:0] ST_HIZ = 3'd5;

  // Parameter record; anything not listed reads as zero. MFR_ID is arbitrary.
  function [7:0] param_byte;
    input [7:0] ofs;
    begin
      case (ofs)
        8'd0: param_byte = 8'h4f;
        8'd1: param_byte = 8'h4e;
        8'd2: param_byte = 8'h46;
        8'd3: param_byte = 8'h49;
        8'd8: param_byte = 8'h02;
        8'd64: param_byte = MFR_ID;
        8'd81: param_byte = 8'h08;
        8'd84: param_byte = 8'h40;
        8'd92: param_byte = 8'h40;
        8'd97: param_byte = 8'h04;
        8'd100: param_byte = 8'h01;
        8'd102: param_byte = 8'h01;
        8'd103: param_byte = 8'h14;
        8'd105: param_byte = 8'h01;
        8'd106: param_byte = 8'h05;
        8'd107: param_byte = 8'h01;
        8'd110: param_byte = 8'h04;
        8'd128: param_byte = 8'h08;
        8'd133: param_byte = 8'hbc;
        8'd134: param_byte = 8'h02;
        8'd135: param_byte = 8'h10;
        8'd136: param_byte = 8'h27;
        8'd137: param_byte = 8'h32;
        default: param_byte = 8'h00; // [RULE19]
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and link synchronisers.
  reg rst_s1_q, rst_n_q;
  reg sclk_s1_q, sclk_s2_q, sclk_s3_q, cs_s1_q, cs_n_q;
  reg [3:0] io_s1_q, io_q;
  wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
  wire sclk_fall = ~sclk_s2_q & sclk_s3_q;

  // Reset is asserted at once and released two clocks later.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Each pin passes two flops; the third clock flop only feeds edge detection.
  always @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_n_q <= 1'b1;
      io_s1_q <= 4'h0;
      io_q <= 4'h0;
    end else begin
      sclk_s1_q <= i_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= i_cs_n;
      cs_n_q <= cs_s1_q;
      io_s1_q <= i_io;
      io_q <= io_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Storage: data buffer and ten OTP pages, the latter erased at power-up.
  reg [7:0] buf_mem [0:2111];
  reg [7:0] otp_mem [0:21119];
  integer k;
  initial begin
    for (k = 0; k < 21120; k = k + 1) begin
      otp_mem[k] = 8'hff; // [RULE13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and page engine state.
  reg [4:0] status2_q;
  reg [7:0] prot1_q;
  reg otp_lock_q, protect_reg_lock, refused_q;
  reg [11:0] buf_ptr_q, eng_cnt_q;
  reg eng_op_q;
  reg [15:0] eng_page_q, cont_page_q;
  reg [7:0] ecc_acc_q;
  wire otp_e = status2_q[`S2_OTP_E];
  wire eff_buf = status2_q[`S2_BUF] | otp_e; // [RULE11]
  wire [14:0] otp_base = (eng_page_q[3:0] - 4'd2) * 15'd2112;
  wire is_otp_pg = (eng_page_q >= `PG_OTP_FIRST) && (eng_page_q <= `PG_OTP_LAST);
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire [2:0] spi_state;
  wire [7:0] buf_rd = buf_mem[buf_ptr_q];

  // Source byte of an extra-page load into the buffer.
  reg [7:0] src_byte;
  always @* begin
    src_byte = 8'h00;
    if (eng_page_q == `PG_UID) begin
      if (eng_cnt_q < `UID_BYTES) begin
        src_byte = UID_RECORD[{~eng_cnt_q[4:0], 3'b000} +: 8]; // [RULE8]
      end
    end else if (eng_page_q == `PG_PARAM) begin
      if (eng_cnt_q < `PARAM_BYTES) begin
        src_byte = param_byte(eng_cnt_q[7:0]); // [RULE20]
      end
    end else if (is_otp_pg) begin
      src_byte = otp_mem[otp_base + {3'b000, eng_cnt_q}];
    end
  end

  // Bus slave, command start, buffer port and the page engine.
  always @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      status2_q <= `S2_RESET;
      prot1_q <= `P1_RESET;
      otp_lock_q <= 1'b0;
      protect_reg_lock <= 1'b0;
      refused_q <= 1'b0;
      buf_ptr_q <= 12'h000;
      eng_cnt_q <= 12'h000;
      eng_op_q <= 1'b0;
      eng_page_q <= 16'h0000;
      cont_page_q <= 16'h0000;
      ecc_acc_q <= 8'h00;
      o_busy <= 1'b0;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req) begin
        o_wb_dat <= 32'h0000_0000;
        if (i_wb_adr == `OFF_STATUS2) begin
          o_wb_dat <= {27'h0, status2_q[4:3], status2_q[2] | protect_reg_lock,
                       status2_q[1] | otp_lock_q, status2_q[0]};
          if (i_wb_we && i_wb_sel[0]) begin
            status2_q <= i_wb_dat[4:0]; // [RULE9] [RULE12]
          end
        end else if (i_wb_adr == `OFF_PROT1) begin
          o_wb_dat <= {24'h0, prot1_q}; // [RULE17]
          if (i_wb_we && i_wb_sel[0] && !protect_reg_lock) begin
            prot1_q <= i_wb_dat[7:0];
          end
        end else if (i_wb_adr == `OFF_CMD) begin
          o_wb_dat <= {cont_page_q, 11'h0, spi_state, refused_q, o_busy};
          if (i_wb_we && i_wb_sel[2] && !o_busy) begin
            eng_op_q <= i_wb_dat[`CMD_OP_BIT];
            eng_page_q <= i_wb_dat[15:0];
            cont_page_q <= i_wb_dat[15:0];
            eng_cnt_q <= 12'h000;
            ecc_acc_q <= 8'h00;
            refused_q <= 1'b0;
            o_busy <= 1'b1; // [RULE10]
          end
        end else if (i_wb_adr == `OFF_BUF_PTR) begin
          o_wb_dat <= {20'h0, buf_ptr_q};
          if (i_wb_we && i_wb_sel[0]) begin
            buf_ptr_q <= i_wb_dat[11:0];
          end
        end else if (i_wb_adr == `OFF_BUF_DATA) begin
          o_wb_dat <= {24'h0, buf_rd};
          if (!o_busy) begin
            if (i_wb_we && i_wb_sel[0]) begin
              buf_mem[buf_ptr_q] <= i_wb_dat[7:0]; // [RULE14]
            end
            buf_ptr_q <= (buf_ptr_q == BUF_LAST) ? 12'h000 : buf_ptr_q + 12'd1;
          end
        end
      end
      if (o_busy) begin
        eng_cnt_q <= eng_cnt_q + 12'd1;
        if (eng_cnt_q == BUF_LAST) begin
          o_busy <= 1'b0;
        end
        if (eng_op_q == `OP_PAGE_READ) begin
          if (otp_e) begin
            buf_mem[eng_cnt_q] <= src_byte; // [RULE10] [RULE6]
          end else begin
            o_busy <= 1'b0;
          end
        end else if (!otp_e) begin
          o_busy <= 1'b0;
        end else if (status2_q[`S2_PROT_LOCK]) begin
          o_busy <= 1'b0;
          if (prot1_q[`P1_SRP_HI] && prot1_q[`P1_SRP_LO]) begin
            protect_reg_lock <= 1'b1; // [RULE18]
          end else begin
            refused_q <= 1'b1;
          end
        end else if (status2_q[`S2_OTP_L]) begin
          o_busy <= 1'b0;
          otp_lock_q <= 1'b1; // [RULE16]
        end else if (otp_lock_q || !is_otp_pg) begin
          o_busy <= 1'b0;
          refused_q <= 1'b1; // [RULE7]
        end else if (eng_cnt_q < `DATA_BYTES) begin
          otp_mem[otp_base + {3'b000, eng_cnt_q}] <=
            src_byte & buf_mem[eng_cnt_q]; // [RULE13] [RULE14]
          ecc_acc_q <= (eng_cnt_q[4:0] == 5'd31) ? 8'h00 : ecc_acc_q ^ buf_mem[eng_cnt_q];
          if (eng_cnt_q[4:0] == 5'd31 && status2_q[`S2_ECC_E]) begin
            otp_mem[otp_base + 15'd2048 + {9'h0, eng_cnt_q[10:5]}] <=
              ecc_acc_q ^ buf_mem[eng_cnt_q]; // [RULE15]
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link sequencer for the quad I/O four-byte-address read.
  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] cmd_q;
  reg [27:0] addr_q;
  reg [11:0] col_q;
  reg hi_q, last_q;
  assign spi_state = st_q;
  wire [3:0] dummy_clks = eff_buf ? `DUMMY_BUF_CLKS : `DUMMY_CONT_CLKS;
  wire [7:0] out_byte = buf_mem[col_q];

  // Command on IO0, then nibble-wide address, dummy and data phases.
  always @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      cmd_q <= 8'h00;
      addr_q <= 28'h0;
      col_q <= 12'h000;
      hi_q <= 1'b1;
      last_q <= 1'b0;
      o_io <= 4'h0;
      o_io_oe <= 4'h0;
    end else if (cs_n_q) begin
      st_q <= ST_IDLE;
      o_io_oe <= 4'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          st_q <= ST_CMD;
          cnt_q <= 4'h0;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            cmd_q <= {cmd_q[6:0], io_q[0]};
            cnt_q <= cnt_q + 4'd1;
            if (cnt_q == 4'd7) begin
              cnt_q <= 4'h0;
              if ({cmd_q[6:0], io_q[0]} == `QIO_READ_4B && !prot1_q[`P1_WP_E]) begin
                st_q <= ST_ADDR;
              end else begin
                st_q <= ST_HIZ; // [RULE5]
              end
            end
          end
        end
        ST_ADDR: begin
          if (sclk_rise) begin
            addr_q <= {addr_q[23:0], io_q}; // [RULE1]
            cnt_q <= cnt_q + 4'd1;
            if (cnt_q == `ADDR_CLKS - 4'd1) begin
              cnt_q <= 4'h0;
              st_q <= ST_DUMMY;
              col_q <= eff_buf ? {addr_q[7:0], io_q} : 12'h000; // [RULE2] [RULE4]
            end
          end
        end
        ST_DUMMY: begin
          o_io_oe <= 4'h0; // [RULE21]
          hi_q <= 1'b1;
          last_q <= 1'b0;
          if (sclk_rise) begin
            cnt_q <= cnt_q + 4'd1;
            if (cnt_q == dummy_clks - 4'd1) begin
              st_q <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sclk_fall) begin
            if (hi_q && last_q) begin
              o_io_oe <= 4'h0;
              st_q <= ST_HIZ; // [RULE3]
            end else if (hi_q) begin
              o_io <= out_byte[7:4]; // [RULE1]
              o_io_oe <= 4'hf;
              hi_q <= 1'b0;
            end else begin
              o_io <= out_byte[3:0];
              hi_q <= 1'b1;
              if (col_q >= BUF_LAST) begin
                col_q <= 12'h000; // [RULE4]
                last_q <= eff_buf; // [RULE2]
              end else begin
                col_q <= col_q + 12'd1;
              end
            end
          end
        end
        default: begin
          o_io_oe <= 4'h0;
        end
      endcase
    end
  end
endmodule

// *** verification/quad_io_read_otp_props.sv ***
// Purpose: Port checks of the quad read and extra-page block.
// Assumes: Classic Wishbone single cycles; mode 0 link clock.
// Notes: Bound to the block below the module.
`timescale 1ns/1ps
`include "quad_io_read_otp_defines.vh"
module quad_io_read_otp_props (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  input wire logic [3:0] o_io,
  input wire logic [3:0] o_io_oe,
  input wire logic o_busy
);
  logic [2:0] sck_q;
  logic [11:0] rise_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Counts link clock rises in the current frame.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sck_q <= 3'h0;
      rise_q <= 12'h000;
    end else begin
      sck_q <= {sck_q[1:0], i_sclk};
      if (i_cs_n)
        rise_q <= 12'h000;
      else if (sck_q[1] && !sck_q[2] && rise_q != 12'hfff)
        rise_q <= rise_q + 12'h001;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // A request not yet answered, and a command write to an idle engine.
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_cmdw;
    s_req ##0 i_wb_we && i_wb_adr == `OFF_CMD && i_wb_sel[2] && !o_busy;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_ACK_NEXT: assert property (s_req |=> o_wb_ack)
    else $error("ack late");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held");
  AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_stb))
    else $error("stray ack");
  AST_UNMAPPED: assert property (s_req ##0 !i_wb_we && i_wb_adr >= 8'h14 |=> o_wb_dat == 0)
    else $error("unmapped read not zero");
  AST_BUSY_START: assert property (s_cmdw |-> ##[1:2] o_busy)
    else $error("busy missing");
  AST_OE_QUAD: assert property (o_io_oe == 4'h0 || o_io_oe == 4'hf)
    else $error("partial drive");
  AST_CS_RELEASE: assert property (i_cs_n [*5] |-> o_io_oe == 4'h0)
    else $error("drive while deselected");
  AST_DUMMY_HIZ: assert property (o_io_oe != 4'h0 && !i_cs_n |-> rise_q >= 12'd22)
    else $error("drive before data");
endmodule
bind quad_io_read_otp quad_io_read_otp_props i_props (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_io(i_io), .o_io(o_io), .o_io_oe(o_io_oe),
  .o_busy(o_busy));

// *** verification/qspi_host_model.sv ***
// Purpose: Host quad link master issuing the quad read.
// Assumes: Mode 0 link clock of 80 ns period.
// Notes: Released lines show the inverse of the last host value.
`timescale 1ns/1ps
module qspi_host_model (
  input wire logic [3:0] i_dev_io,
  input wire logic [3:0] i_dev_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io
);
  logic [3:0] drv, smp, soe;
  logic [7:0] got [0:3];
  logic [3:0] got_oe [0:3];
  logic any_oe, dum_oe;
  // The device wins where it drives.
  assign o_io = (i_dev_oe & i_dev_io) | (~i_dev_oe & drv);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    drv = 4'h0;
  end
  // One clock; the wire is sampled just before the fall.
  task automatic pulse;
    #40 o_sclk = 1'b1;
    #40 smp = o_io;
    soe = i_dev_oe;
    any_oe = any_oe | (|i_dev_oe);
    o_sclk = 1'b0;
  endtask
  // Command, four address bytes, dummy clocks, then nb bytes.
  task automatic frame(input logic [15:0] col, input int ndum, input int nb);
    logic [39:0] sh;
    sh = {8'hec, 16'h0000, col};
    any_oe = 1'b0;
    #3 o_cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      drv = (i < 8) ? {3'b000, sh[39-i]} : sh[63-4*i -: 4];
      pulse();
    end
    drv = ~drv;
    repeat (ndum) pulse();
    dum_oe = any_oe;
    for (int i = 0; i < 2 * nb; i++) begin
      pulse();
      got[i/2] = {got[i/2][3:0], smp};
      got_oe[i/2] = soe;
    end
    #40 o_cs_n = 1'b1;
    #160;
  endtask
endmodule

// *** verification/quad_io_read_otp_bench.sv ***
// Purpose: Self-checking bench of the quad read and extra-page block.
// Assumes: Default record parameters; link clock 80 ns.
// Notes: Registers through classic Wishbone single cycles.
`timescale 1ns/1ps
`include "quad_io_read_otp_defines.vh"
module quad_io_read_otp_bench;
  logic i_clk, i_arst_n, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_sclk, i_cs_n, o_busy;
  logic [7:0] i_wb_adr;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic [3:0] i_wb_sel, i_io, o_io, o_io_oe;
  int n_fail, checks_done;
  quad_io_read_otp i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
    .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sclk(i_sclk),
    .i_cs_n(i_cs_n), .i_io(i_io), .o_io(o_io), .o_io_oe(o_io_oe), .o_busy(o_busy));
  qspi_host_model i_host (.i_dev_io(o_io), .i_dev_oe(o_io_oe), .o_sclk(i_sclk),
    .o_cs_n(i_cs_n), .o_io(i_io));
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bounded waits.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_sel <= 4'hf;
    i_wb_adr <= a;
    i_wb_dat <= d;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 20);
    if (o_wb_ack !== 1'b1) begin
      n_fail++;
      print_verdict;
    end
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task cmd(input logic [31:0] c);
    int k;
    wb(1, `OFF_CMD, c);
    k = 0;
    while (o_busy !== 1'b0 && k < 3000) begin
      @(posedge i_clk);
      k++;
    end
    if (o_busy !== 1'b0) begin
      n_fail++;
      print_verdict;
    end
  endtask
  task rdb(input logic [31:0] p);
    wb(1, `OFF_BUF_PTR, p);
    wb(0, `OFF_BUF_DATA, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped read.
  task t_regs;
    wb(0, `OFF_STATUS2, 0);
    chk(rd, 32'h18);
    wb(0, `OFF_PROT1, 0);
    chk(rd, 32'h00);
    wb(0, 8'h20, 0);
    chk(rd, 32'h00);
  endtask
  // ID page over the link in extra-page mode with buffer bit cleared, then in continuous mode.
  task t_uid;
    wb(1, `OFF_STATUS2, 32'h19);
    cmd(32'h0000_0000);
    wb(1, `OFF_STATUS2, 32'h09);
    i_host.frame(16'd31, 6, 2);
    chk(i_host.got[0], 8'hf0);
    chk(i_host.got[1], 8'h01);
    chk(i_host.dum_oe, 1'b0);
    i_host.frame(16'd2110, 6, 3);
    chk(i_host.got[1], 8'h00);
    chk(i_host.got_oe[1], 4'hf);
    chk(i_host.got_oe[2], 4'h0);
    wb(1, `OFF_STATUS2, 32'h08);
    i_host.frame(16'd31, 10, 2);
    chk(i_host.got[0], 8'h01);
    chk(i_host.got[1], 8'h23);
  endtask
  // Parameter copies and the zero tail.
  task t_param;
    wb(1, `OFF_STATUS2, 32'h19);
    cmd(32'h0000_0001);
    rdb(0);
    chk(rd, 32'h4f);
    rdb(256);
    chk(rd, 32'h4f);
    rdb(512);
    chk(rd, 32'h4f);
    rdb(266);
    chk(rd, 32'h00);
    rdb(800);
    chk(rd, 32'h00);
  endtask
  // Program twice; bits only fall, check bytes land in the spare.
  task t_prog;
    cmd(32'h0000_0002);
    wb(1, `OFF_BUF_PTR, 0);
    wb(1, `OFF_BUF_DATA, 32'h3c);
    cmd(32'h0001_0002);
    cmd(32'h0000_0002);
    rdb(0);
    chk(rd, 32'h3c);
    rdb(1);
    chk(rd, 32'hff);
    rdb(2048);
    chk(rd, 32'hc3);
    wb(1, `OFF_BUF_PTR, 0);
    wb(1, `OFF_BUF_DATA, 32'hc0);
    cmd(32'h0001_0002);
    cmd(32'h0000_0002);
    rdb(0);
    chk(rd, 32'h00);
  endtask
  // OTP lock, register lock, then the quad read under write-protect.
  task t_lock;
    wb(1, `OFF_STATUS2, 32'h1b);
    cmd(32'h0001_0007);
    wb(1, `OFF_STATUS2, 32'h19);
    wb(0, `OFF_STATUS2, 0);
    chk(rd[1], 1'b1);
    cmd(32'h0001_0003);
    wb(0, `OFF_CMD, 0);
    chk(rd, 32'h0003_0002);
    wb(1, `OFF_PROT1, 32'h20);
    wb(1, `OFF_STATUS2, 32'h1d);
    cmd(32'h0001_0000);
    wb(0, `OFF_CMD, 0);
    chk(rd[1], 1'b1);
    wb(1, `OFF_PROT1, 32'he0);
    cmd(32'h0001_0000);
    wb(0, `OFF_CMD, 0);
    chk(rd, 32'h0000_0000);
    wb(1, `OFF_PROT1, 32'h00);
    wb(0, `OFF_PROT1, 0);
    chk(rd, 32'he0);
    wb(1, `OFF_STATUS2, 32'h08);
    i_host.frame(16'd0, 10, 1);
    chk(i_host.any_oe, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_arst_n = 1'b0;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 8'h00;
    i_wb_dat = 32'h0;
    i_wb_sel = 4'hf;
    n_fail = 0;
    checks_done = 0;
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_regs;
    t_uid;
    t_param;
    t_prog;
    t_lock;
    print_verdict;
  end
endmodule
